// >>> src/dms_defines.svh
// Register indices, field limits and reset values of the setting bank
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_IDX_W          14
`define DMS_IDX_LIFE       14'h101D
`define DMS_IDX_SEQ_PC     14'h101E
`define DMS_IDX_SEQ_NUM    14'h101F
`define DMS_IDX_DC_BUS     14'h1026
`define DMS_IDX_BRAKE      14'h1027
`define DMS_IDX_THERMAL    14'h1028
`define DMS_IDX_USER1_HI   14'h102E
`define DMS_IDX_USER1_LO   14'h102F
`define DMS_IDX_USER2_HI   14'h1030
`define DMS_IDX_USER2_LO   14'h1031
`define DMS_IDX_USER3_HI   14'h1032
`define DMS_IDX_USER3_LO   14'h1033
`define DMS_IDX_POS_TGT_HI 14'h1036
`define DMS_IDX_POS_TGT_LO 14'h1037
`define DMS_IDX_POS_ACT_HI 14'h1038
`define DMS_IDX_POS_ACT_LO 14'h1039
`define DMS_IDX_MODE       14'h1057
`define DMS_IDX_ACCEL_HI   14'h1103
`define DMS_IDX_ACCEL_LO   14'h1104
`define DMS_IDX_DECEL_HI   14'h1105
`define DMS_IDX_DECEL_LO   14'h1106
`define DMS_IDX_RUN_DIR    14'h1107
`define DMS_IDX_FREQ_SRC   14'h1201
`define DMS_IDX_RUN_SRC    14'h1202
`define DMS_IDX_BASE_FREQ  14'h1203
`define DMS_IDX_MAX_FREQ   14'h1204
`define DMS_IDX_AIN_SW     14'h1205
`define DMS_IDX_VSTART_HI  14'h120B
`define DMS_IDX_VSTART_LO  14'h120C
`define DMS_IDX_VEND_HI    14'h120D
`define DMS_IDX_VEND_LO    14'h120E
`define DMS_IDX_START_PCT  14'h120F
`define DMS_IDX_END_PCT    14'h1210
`define DMS_IDX_START_SEL  14'h1211
`define DMS_IDX_CTRL       14'h1300
`define DMS_IDX_IRQ_STAT   14'h1301
`define DMS_IDX_IRQ_MASK   14'h1302
`define DMS_LOAD_MAX       16'h03E8
`define DMS_RAMP_MIN       32'h0000_0001
`define DMS_RAMP_MAX       32'h0005_7E40
`define DMS_FREQ_MIN       16'h012C
`define DMS_FMAX_STD       16'h0FA0
`define DMS_FMAX_EXT       16'h2710
`define DMS_VFREQ_STD      32'h0000_9C40
`define DMS_VFREQ_EXT      32'h0001_86A0
`define DMS_PCT_MAX        16'h0064
`define DMS_RST_RAMP       32'h0000_03E8
`define DMS_RST_FSRC       16'h0000
`define DMS_RST_RSRC       16'h0002
`define DMS_RST_BASE       16'h0258
`define DMS_RST_FMAX       16'h0258
`define DMS_RST_START_SEL  16'h0001
`define DMS_EV_CAP         0
`define DMS_EV_FAN         1
`define DMS_EV_REJECT      2
`define DMS_EV_W           3
`endif

// >>> src/dms_pkg.sv
// Types shared by the drive monitor and setting bank
package dms_pkg;
	typedef struct packed {
		logic [1:0]  life;
		logic [15:0] seq_pc;
		logic [15:0] seq_num;
		logic [15:0] dc_bus;
		logic [15:0] brake;
		logic [15:0] thermal;
		logic [31:0] user1;
		logic [31:0] user2;
		logic [31:0] user3;
		logic [31:0] pos_tgt;
		logic [31:0] pos_act;
		logic [1:0]  mode;
	} dms_monitor_type;
	typedef struct packed {
		logic [31:0] accel;
		logic [31:0] decel;
		logic [31:0] vstart;
		logic [31:0] vend;
		logic [15:0] run_dir;
		logic [15:0] freq_src;
		logic [15:0] run_src;
		logic [15:0] base;
		logic [15:0] fmax;
		logic [15:0] ain_sw;
		logic [15:0] start_pct;
		logic [15:0] end_pct;
		logic [15:0] start_sel;
	} dms_setting_type;
endpackage : dms_pkg

// >>> src/dms_regs.sv
// APB register bank of drive monitors and first setting group
// Summary of operation
// RULE1: Read-only life flags: bit 0 capacitor end of life, bit 1 fan.
// RULE2: Thermal overload is read-only, 0 to 1000 in 0.1 percent steps.
// RULE3: Brake resistor load is read-only, 0 to 1000 in 0.1 percent steps.
// RULE4: Read-only mode: 0 constant torque, 1 variable torque, 3 magnet motor.
// RULE5: Accel and decel times are 32-bit pairs of 1 to 360000 in 0.01 s.
// RULE6: Keypad run direction takes 0 for forward and 1 for reverse.
// RULE7: The frequency source accepts 0, 1, 2, 3, 4, 6, 7 and 10.
// RULE8: The run command source accepts only 1 to 4.
// RULE9: Base is 300 to maximum; maximum 300 to 4000, or 10000 extended; a maximum above 4000 stays stored when the extended range is cleared.
// RULE10: The analog input switch selection accepts 0, 2 and 3.
// RULE11: Voltage input start/end frequencies: 0 to 40000, or 100000 extended; values above 40000 stay stored when the extended range is cleared.
// RULE12: Start percentage is at most end percentage, which is at most 100.
// RULE13: Start frequency select: 0 external start frequency, 1 for 0 Hz.
// RULE14: Pairs hold the high half at the lower address, low half next.
// RULE15: Bad address, read-only write or bad value: error, nothing changed.
// RULE16: Master writes both halves before use, and only listed encodings.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "dms_defines.svh"
module dms_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [15:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	input  wire dms_pkg::dms_monitor_type mon,
	output dms_pkg::dms_setting_type   setting,
	output logic                       ext_range,
	output logic                       irq
);
	// ********************************
	// Bus decode
	// ********************************
	logic [`DMS_IDX_W-1:0]   idx;
	logic                    acc_first;
	logic                    acc_done;
	logic [15:0]             wval;
	logic [15:0]             fmax_lim;
	logic [31:0]             vfreq_lim;
	logic [31:0]             pair_val;
	logic                    hit;
	logic                    ro;
	logic                    bad;
	logic [31:0]             rdata;

	dms_pkg::dms_setting_type set_ff;
	dms_pkg::dms_setting_type nxt_set;
	logic [15:0]             stage_ff [4];
	logic [15:0]             nxt_stage [4];
	logic                    pready_ff;
	logic                    nxt_pready;
	logic [31:0]             prdata_ff;
	logic [31:0]             nxt_prdata;
	logic                    pslverr_ff;
	logic                    nxt_pslverr;
	logic                    ext_ff;
	logic                    nxt_ext;
	logic [`DMS_EV_W-1:0]    stat_ff;
	logic [`DMS_EV_W-1:0]    nxt_stat;
	logic [`DMS_EV_W-1:0]    mask_ff;
	logic [`DMS_EV_W-1:0]    nxt_mask;
	logic [1:0]              life_ff;
	logic                    irq_ff;
	logic                    nxt_irq;

	assign idx       = paddr[15:2];
	assign acc_first = psel && penable && !pready_ff;
	assign acc_done  = psel && penable && pready_ff;
	assign wval      = pwdata[15:0];
	assign fmax_lim  = ext_ff ? `DMS_FMAX_EXT : `DMS_FMAX_STD; // RULE9
	assign vfreq_lim = ext_ff ? `DMS_VFREQ_EXT : `DMS_VFREQ_STD; // RULE11

	// Saturate load monitors so a glitching source never reads out of range
	function automatic logic [31:0] load_clamp(input logic [15:0] v);
		load_clamp = {16'h0000, (v > `DMS_LOAD_MAX) ? `DMS_LOAD_MAX : v};
	endfunction : load_clamp

	// ********************************
	// Read mux and access check
	// ********************************
	always_comb begin
		rdata    = 32'h0000_0000;
		hit      = 1'b1;
		ro       = 1'b1;
		pair_val = 32'h0000_0000;
		bad      = 1'b0;
		unique case (idx)
			`DMS_IDX_LIFE:       rdata = {30'h0, mon.life}; // RULE1
			`DMS_IDX_SEQ_PC:     rdata = {16'h0, mon.seq_pc};
			`DMS_IDX_SEQ_NUM:    rdata = {16'h0, mon.seq_num};
			`DMS_IDX_DC_BUS:     rdata = {16'h0, mon.dc_bus};
			`DMS_IDX_BRAKE:      rdata = load_clamp(mon.brake); // RULE3
			`DMS_IDX_THERMAL:    rdata = load_clamp(mon.thermal); // RULE2
			`DMS_IDX_USER1_HI:   rdata = {16'h0, mon.user1[31:16]}; // RULE14
			`DMS_IDX_USER1_LO:   rdata = {16'h0, mon.user1[15:0]};
			`DMS_IDX_USER2_HI:   rdata = {16'h0, mon.user2[31:16]};
			`DMS_IDX_USER2_LO:   rdata = {16'h0, mon.user2[15:0]};
			`DMS_IDX_USER3_HI:   rdata = {16'h0, mon.user3[31:16]};
			`DMS_IDX_USER3_LO:   rdata = {16'h0, mon.user3[15:0]};
			`DMS_IDX_POS_TGT_HI: rdata = {16'h0, mon.pos_tgt[31:16]};
			`DMS_IDX_POS_TGT_LO: rdata = {16'h0, mon.pos_tgt[15:0]};
			`DMS_IDX_POS_ACT_HI: rdata = {16'h0, mon.pos_act[31:16]};
			`DMS_IDX_POS_ACT_LO: rdata = {16'h0, mon.pos_act[15:0]};
			`DMS_IDX_MODE:       rdata = {30'h0, mon.mode}; // RULE4
			`DMS_IDX_IRQ_STAT:   rdata = {29'h0, stat_ff};
			`DMS_IDX_ACCEL_HI,
			`DMS_IDX_DECEL_HI,
			`DMS_IDX_VSTART_HI,
			`DMS_IDX_VEND_HI: begin
				ro = 1'b0;
			end
			`DMS_IDX_ACCEL_LO: begin
				ro       = 1'b0;
				rdata    = {16'h0, set_ff.accel[15:0]};
				pair_val = {stage_ff[0], wval};
				bad      = pair_val < `DMS_RAMP_MIN || pair_val > `DMS_RAMP_MAX; // RULE5
			end
			`DMS_IDX_DECEL_LO: begin
				ro       = 1'b0;
				rdata    = {16'h0, set_ff.decel[15:0]};
				pair_val = {stage_ff[1], wval};
				bad      = pair_val < `DMS_RAMP_MIN || pair_val > `DMS_RAMP_MAX; // RULE5
			end
			`DMS_IDX_VSTART_LO: begin
				ro       = 1'b0;
				rdata    = {16'h0, set_ff.vstart[15:0]};
				pair_val = {stage_ff[2], wval};
				bad      = pair_val > vfreq_lim; // RULE11
			end
			`DMS_IDX_VEND_LO: begin
				ro       = 1'b0;
				rdata    = {16'h0, set_ff.vend[15:0]};
				pair_val = {stage_ff[3], wval};
				bad      = pair_val > vfreq_lim; // RULE11
			end
			`DMS_IDX_RUN_DIR: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.run_dir};
				bad   = wval > 16'h0001; // RULE6
			end
			`DMS_IDX_FREQ_SRC: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.freq_src};
				bad   = !(wval <= 16'h0004 || wval == 16'h0006 ||
					wval == 16'h0007 || wval == 16'h000A); // RULE7
			end
			`DMS_IDX_RUN_SRC: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.run_src};
				bad   = wval < 16'h0001 || wval > 16'h0004; // RULE8
			end
			`DMS_IDX_BASE_FREQ: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.base};
				bad   = wval < `DMS_FREQ_MIN || wval > set_ff.fmax; // RULE9
			end
			`DMS_IDX_MAX_FREQ: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.fmax};
				// Refusing a maximum below base keeps base valid at all times
				bad   = wval < `DMS_FREQ_MIN || wval > fmax_lim ||
					wval < set_ff.base; // RULE9
			end
			`DMS_IDX_AIN_SW: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.ain_sw};
				bad   = !(wval == 16'h0000 || wval == 16'h0002 ||
					wval == 16'h0003); // RULE10
			end
			`DMS_IDX_START_PCT: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.start_pct};
				bad   = wval > set_ff.end_pct; // RULE12
			end
			`DMS_IDX_END_PCT: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.end_pct};
				bad   = wval < set_ff.start_pct || wval > `DMS_PCT_MAX; // RULE12
			end
			`DMS_IDX_START_SEL: begin
				ro    = 1'b0;
				rdata = {16'h0, set_ff.start_sel};
				bad   = wval > 16'h0001; // RULE13
			end
			`DMS_IDX_CTRL: begin
				ro    = 1'b0;
				rdata = {31'h0, ext_ff};
				bad   = wval > 16'h0001;
			end
			`DMS_IDX_IRQ_MASK: begin
				ro    = 1'b0;
				rdata = {29'h0, mask_ff};
				bad   = wval > 16'h0007;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		// High halves read the committed value, not the staged one
		unique case (idx)
			`DMS_IDX_ACCEL_HI:  rdata = {16'h0, set_ff.accel[31:16]}; // RULE14
			`DMS_IDX_DECEL_HI:  rdata = {16'h0, set_ff.decel[31:16]};
			`DMS_IDX_VSTART_HI: rdata = {16'h0, set_ff.vstart[31:16]};
			`DMS_IDX_VEND_HI:   rdata = {16'h0, set_ff.vend[31:16]};
			default:            rdata = rdata;
		endcase
	end

	// ********************************
	// Bus answer and setting update
	// ********************************
	always_comb begin
		nxt_pready  = acc_first;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = 1'b0;
		nxt_set     = set_ff;
		nxt_stage   = stage_ff;
		nxt_ext     = ext_ff;
		nxt_mask    = mask_ff;
		if (acc_first) begin
			nxt_prdata  = pwrite ? 32'h0000_0000 : rdata;
			nxt_pslverr = !hit || paddr[1:0] != 2'b00 ||
				(pwrite && (ro || bad || pwdata[31:16] != 16'h0000)); // RULE15
		end
		// Commit only on the completing edge, and only when accepted
		if (acc_done && pwrite && !pslverr_ff) begin
			unique case (idx)
				`DMS_IDX_ACCEL_HI:  nxt_stage[0] = wval; // RULE14
				`DMS_IDX_DECEL_HI:  nxt_stage[1] = wval;
				`DMS_IDX_VSTART_HI: nxt_stage[2] = wval;
				`DMS_IDX_VEND_HI:   nxt_stage[3] = wval;
				`DMS_IDX_ACCEL_LO:  nxt_set.accel = {stage_ff[0], wval}; // RULE5
				`DMS_IDX_DECEL_LO:  nxt_set.decel = {stage_ff[1], wval};
				`DMS_IDX_VSTART_LO: nxt_set.vstart = {stage_ff[2], wval}; // RULE11
				`DMS_IDX_VEND_LO:   nxt_set.vend = {stage_ff[3], wval};
				`DMS_IDX_RUN_DIR:   nxt_set.run_dir = wval; // RULE6
				`DMS_IDX_FREQ_SRC:  nxt_set.freq_src = wval; // RULE7
				`DMS_IDX_RUN_SRC:   nxt_set.run_src = wval; // RULE8
				`DMS_IDX_BASE_FREQ: nxt_set.base = wval; // RULE9
				`DMS_IDX_MAX_FREQ:  nxt_set.fmax = wval;
				`DMS_IDX_AIN_SW:    nxt_set.ain_sw = wval; // RULE10
				`DMS_IDX_START_PCT: nxt_set.start_pct = wval; // RULE12
				`DMS_IDX_END_PCT:   nxt_set.end_pct = wval;
				`DMS_IDX_START_SEL: nxt_set.start_sel = wval; // RULE13
				`DMS_IDX_CTRL:      nxt_ext = wval[0];
				`DMS_IDX_IRQ_MASK:  nxt_mask = wval[`DMS_EV_W-1:0];
				default:            nxt_ext = ext_ff;
			endcase
		end
	end

	// ********************************
	// Events and interrupt
	// ********************************
	always_comb begin
		nxt_stat = stat_ff;
		if (acc_done && !pwrite && !pslverr_ff && idx == `DMS_IDX_IRQ_STAT) begin
			nxt_stat = '0;
		end
		// Set after clear so an event in the clearing cycle survives
		if (mon.life[0] && !life_ff[0]) nxt_stat[`DMS_EV_CAP] = 1'b1;
		if (mon.life[1] && !life_ff[1]) nxt_stat[`DMS_EV_FAN] = 1'b1;
		if (acc_done && pslverr_ff) nxt_stat[`DMS_EV_REJECT] = 1'b1;
		nxt_irq = |(nxt_stat & mask_ff);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff          <= 1'b0;
			prdata_ff          <= 32'h0000_0000;
			pslverr_ff         <= 1'b0;
			set_ff.accel       <= `DMS_RST_RAMP;
			set_ff.decel       <= `DMS_RST_RAMP;
			set_ff.vstart      <= 32'h0000_0000;
			set_ff.vend        <= 32'h0000_0000;
			set_ff.run_dir     <= 16'h0000;
			set_ff.freq_src    <= `DMS_RST_FSRC;
			set_ff.run_src     <= `DMS_RST_RSRC;
			set_ff.base        <= `DMS_RST_BASE;
			set_ff.fmax        <= `DMS_RST_FMAX;
			set_ff.ain_sw      <= 16'h0000;
			set_ff.start_pct   <= 16'h0000;
			set_ff.end_pct     <= `DMS_PCT_MAX;
			set_ff.start_sel   <= `DMS_RST_START_SEL;
			stage_ff           <= '{4{16'h0000}};
			ext_ff             <= 1'b0;
			mask_ff            <= '0;
			stat_ff            <= '0;
			life_ff            <= 2'b00;
			irq_ff             <= 1'b0;
		end else begin
			pready_ff  <= nxt_pready;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			set_ff     <= nxt_set;
			stage_ff   <= nxt_stage;
			ext_ff     <= nxt_ext;
			mask_ff    <= nxt_mask;
			stat_ff    <= nxt_stat;
			life_ff    <= mon.life;
			irq_ff     <= nxt_irq;
		end
	end

	assign pready    = pready_ff;
	assign prdata    = prdata_ff;
	assign pslverr   = pslverr_ff;
	assign setting   = set_ff;
	assign ext_range = ext_ff;
	assign irq       = irq_ff;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	answer_one_cycle_a: assert property (
		acc_first |=> pready_ff ##1 !pready_ff)
		else $error("answer not one cycle after access");
	life_read_a: assert property ( // RULE1
		acc_first && !pwrite && idx == `DMS_IDX_LIFE
		|=> prdata_ff == {30'h0, $past(mon.life)})
		else $error("life flags read wrong");
	thermal_range_a: assert property ( // RULE2
		acc_first && !pwrite && idx == `DMS_IDX_THERMAL
		|=> prdata_ff <= {16'h0000, `DMS_LOAD_MAX})
		else $error("thermal load above 1000");
	brake_range_a: assert property ( // RULE3
		acc_first && !pwrite && idx == `DMS_IDX_BRAKE
		|=> prdata_ff <= {16'h0000, `DMS_LOAD_MAX})
		else $error("brake load above 1000");
	mode_readonly_a: assert property ( // RULE4
		acc_first && pwrite && idx == `DMS_IDX_MODE |=> pslverr_ff)
		else $error("mode write not refused");
	ramp_range_a: assert property ( // RULE5
		set_ff.accel >= `DMS_RAMP_MIN && set_ff.accel <= `DMS_RAMP_MAX)
		else $error("accel out of range");
	run_src_a: assert property ( // RULE8
		set_ff.run_src >= 16'h0001 && set_ff.run_src <= 16'h0004)
		else $error("run source illegal");
	base_max_a: assert property ( // RULE9
		set_ff.base <= set_ff.fmax && set_ff.base >= `DMS_FREQ_MIN)
		else $error("base above maximum");
	pct_order_a: assert property ( // RULE12
		set_ff.start_pct <= set_ff.end_pct && set_ff.end_pct <= `DMS_PCT_MAX)
		else $error("percentages out of order");
	reject_keeps_a: assert property ( // RULE15
		acc_done && pslverr_ff
		|=> $stable(set_ff) && stat_ff[`DMS_EV_REJECT])
		else $error("rejected write changed settings");
	irq_follow_a: assert property (
		irq_ff == |(stat_ff & $past(mask_ff)))
		else $error("interrupt not following status");

	write_ok_c: cover property (acc_done && pwrite && !pslverr_ff);
	write_bad_c: cover property (acc_done && pwrite && pslverr_ff);
	pair_commit_c: cover property (acc_done && pwrite && !pslverr_ff &&
		idx == `DMS_IDX_ACCEL_LO);
	irq_rise_c: cover property ($rose(irq_ff));
endmodule : dms_regs

// >>> verif/dms_apb_master.sv
// APB master model standing for the serial protocol controller
`timescale 1ns/10ps
module dms_apb_master (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [15:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// ************************************************
	// Bus cycles
	// ************************************************
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
	end

	// No cycle limit here; the bench watchdog cuts a hang short
	task automatic xfer(input logic w, input logic [13:0] idx,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data bus flips so a stale value is never reused
		pwdata <= ~d;
	endtask : xfer

	// High half at the lower index goes first, then the low half
	task automatic xfer32(input logic [13:0] idx, input logic [31:0] d,
		output logic err);
		logic [31:0] rd;
		logic        e;
		xfer(1'b1, idx, {16'h0000, d[31:16]}, rd, e);
		xfer(1'b1, idx + 14'h0001, {16'h0000, d[15:0]}, rd, err);
		err = err | e;
	endtask : xfer32
endmodule : dms_apb_master

// >>> verif/test_dms_regs.sv
// Self-checking bench of the drive monitor and setting bank
`timescale 1ns/10ps
`include "dms_defines.svh"
module test_dms_regs;
	logic                     pclk;
	logic                     presetn;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [15:0]              paddr;
	logic [31:0]              pwdata;
	logic                     pready;
	logic [31:0]              prdata;
	logic                     pslverr;
	logic                     ext_range;
	logic                     irq;
	dms_pkg::dms_monitor_type mon;
	dms_pkg::dms_setting_type setting;
	logic [31:0]              rd;
	logic                     er;
	int                       n_fail;
	int                       cmp_count;
	int                       cyc;

	dms_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .mon(mon),
		.setting(setting), .ext_range(ext_range), .irq(irq));

	dms_apb_master u_mst (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ************************************************
	// Access and compare tasks
	// ************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [13:0] i, input logic [31:0] d,
		input logic ee);
		u_mst.xfer(1'b1, i, d, rd, er);
		chk({31'h0, er}, {31'h0, ee});
	endtask : wr

	task automatic rdc(input logic [13:0] i, input logic [31:0] ex,
		input logic ee);
		u_mst.xfer(1'b0, i, 32'h0000_0000, rd, er);
		chk({31'h0, er}, {31'h0, ee});
		if (!ee) chk(rd, ex);
	endtask : rdc

	task automatic w32(input logic [13:0] i, input logic [31:0] d,
		input logic ee);
		u_mst.xfer32(i, d, er);
		chk({31'h0, er}, {31'h0, ee});
	endtask : w32

	// Tries codes 0..n-1; rejected codes must leave the last good one
	task automatic sweep(input logic [13:0] i, input int n,
		input logic [15:0] ok, input logic [15:0] keep);
		for (int v = 0; v < n; v++) begin
			wr(i, 32'(v), !ok[v]);
			if (ok[v]) keep = 16'(v);
			rdc(i, {16'h0, keep}, 1'b0);
		end
	endtask : sweep

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end

	// ************************************************
	// Test sequence
	// ************************************************
	initial begin
		presetn = 1'b0;
		mon = '0;
		n_fail = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`DMS_IDX_ACCEL_HI, 32'h0, 1'b0);
		rdc(`DMS_IDX_DECEL_LO, 32'h03E8, 1'b0);
		rdc(`DMS_IDX_BASE_FREQ, 32'h0258, 1'b0);
		rdc(`DMS_IDX_END_PCT, 32'h0064, 1'b0);
		mon.life <= 2'b10;
		mon.brake <= 16'h03E7;
		mon.thermal <= 16'h04D2;
		mon.user1 <= 32'hFFFF_FFFE;
		mon.pos_act <= 32'h8000_0001;
		mon.pos_tgt <= 32'hF000_0001;
		rdc(`DMS_IDX_LIFE, 32'h2, 1'b0);
		rdc(`DMS_IDX_BRAKE, 32'h03E7, 1'b0);
		rdc(`DMS_IDX_THERMAL, 32'h03E8, 1'b0);
		rdc(`DMS_IDX_USER1_HI, 32'hFFFF, 1'b0);
		rdc(`DMS_IDX_USER1_LO, 32'hFFFE, 1'b0);
		rdc(`DMS_IDX_POS_ACT_HI, 32'h8000, 1'b0);
		rdc(`DMS_IDX_POS_ACT_LO, 32'h0001, 1'b0);
		rdc(`DMS_IDX_POS_TGT_HI, 32'hF000, 1'b0);
		rdc(`DMS_IDX_POS_TGT_LO, 32'h0001, 1'b0);
		// Code 2 is unused; only modes 0, 1 and 3 are driven and read back
		for (int m = 0; m < 4; m++) begin
			if (m != 2) begin
				mon.mode <= 2'(m);
				rdc(`DMS_IDX_MODE, 32'(m), 1'b0);
			end
		end
		wr(`DMS_IDX_LIFE, 32'h0, 1'b1);
		wr(`DMS_IDX_THERMAL, 32'h0, 1'b1);
		wr(`DMS_IDX_MODE, 32'h0, 1'b1);
		rdc(14'h1020, 32'h0, 1'b1);
		wr(14'h1108, 32'h0, 1'b1);
		rdc(14'h1206, 32'h0, 1'b1);
		wr(`DMS_IDX_RUN_DIR, 32'h0001_0000, 1'b1);
		w32(`DMS_IDX_ACCEL_HI, 32'h0005_7E40, 1'b0);
		w32(`DMS_IDX_ACCEL_HI, 32'h0005_7E41, 1'b1);
		w32(`DMS_IDX_ACCEL_HI, 32'h0, 1'b1);
		w32(`DMS_IDX_DECEL_HI, 32'h1, 1'b0);
		#1;
		chk(setting.accel, 32'h0005_7E40);
		chk(setting.decel, 32'h1);
		rdc(`DMS_IDX_ACCEL_HI, 32'h0005, 1'b0);
		sweep(`DMS_IDX_RUN_DIR, 3, 16'h0003, 16'h0);
		sweep(`DMS_IDX_FREQ_SRC, 12, 16'h04DF, 16'h0);
		sweep(`DMS_IDX_RUN_SRC, 6, 16'h001E, 16'h2);
		sweep(`DMS_IDX_AIN_SW, 5, 16'h000D, 16'h0);
		sweep(`DMS_IDX_START_SEL, 3, 16'h0003, 16'h1);
		wr(`DMS_IDX_MAX_FREQ, 32'h0FA1, 1'b1);
		wr(`DMS_IDX_MAX_FREQ, 32'h0FA0, 1'b0);
		wr(`DMS_IDX_BASE_FREQ, 32'h0FA1, 1'b1);
		wr(`DMS_IDX_BASE_FREQ, 32'h012B, 1'b1);
		wr(`DMS_IDX_BASE_FREQ, 32'h012C, 1'b0);
		wr(`DMS_IDX_MAX_FREQ, 32'h012B, 1'b1);
		wr(`DMS_IDX_BASE_FREQ, 32'h0FA0, 1'b0);
		wr(`DMS_IDX_MAX_FREQ, 32'h0F9F, 1'b1);
		w32(`DMS_IDX_VSTART_HI, 32'h0001_86A0, 1'b1);
		wr(`DMS_IDX_CTRL, 32'h1, 1'b0);
		wr(`DMS_IDX_MAX_FREQ, 32'h2711, 1'b1);
		wr(`DMS_IDX_MAX_FREQ, 32'h2710, 1'b0);
		w32(`DMS_IDX_VSTART_HI, 32'h0001_86A0, 1'b0);
		w32(`DMS_IDX_VSTART_HI, 32'h0001_86A1, 1'b1);
		#1;
		chk({31'h0, ext_range}, 32'h1);
		chk(setting.vstart, 32'h0001_86A0);
		wr(`DMS_IDX_CTRL, 32'h0, 1'b0);
		w32(`DMS_IDX_VEND_HI, 32'h0000_9C41, 1'b1);
		w32(`DMS_IDX_VEND_HI, 32'h0000_9C40, 1'b0);
		wr(`DMS_IDX_END_PCT, 32'h0065, 1'b1);
		wr(`DMS_IDX_END_PCT, 32'h0032, 1'b0);
		wr(`DMS_IDX_START_PCT, 32'h0033, 1'b1);
		wr(`DMS_IDX_START_PCT, 32'h0032, 1'b0);
		wr(`DMS_IDX_END_PCT, 32'h0031, 1'b1);
		#1;
		chk({setting.base, setting.fmax}, 32'h0FA0_2710);
		chk({setting.start_pct, setting.end_pct}, 32'h0032_0032);
		chk(setting.vend, 32'h0000_9C40);
		wr(`DMS_IDX_IRQ_MASK, 32'h4, 1'b0);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h1);
		rdc(`DMS_IDX_IRQ_STAT, 32'h6, 1'b0);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h0);
		@(posedge pclk);
		mon.life <= 2'b11;
		repeat (3) @(posedge pclk);
		#1;
		chk({31'h0, irq}, 32'h0);
		rdc(`DMS_IDX_IRQ_STAT, 32'h1, 1'b0);
		close_out();
	end
endmodule : test_dms_regs
